// [rtl/ccap_pkg.sv]
// Purpose: Shared constants for the capture/compare array
// Assumes: Single 200 MHz core clock
// Notes:   Mode, edge and source codes match the top-level config ports
package ccap_pkg;
    localparam int          NCH       = 16;
    localparam int          NPIN      = 12;
    localparam int          TW        = 16;
    localparam int          NPAIR     = 8;
    localparam int          PAIR_OFS  = 8;
    localparam int          PDIV_W    = 12;
    localparam int          CLK_MHZ   = 200;
    typedef logic [TW-1:0]  ccap_word_t;
    // Channel modes
    localparam logic [2:0]  MD_OFF    = 3'h0;
    localparam logic [2:0]  MD_CAP    = 3'h1;
    localparam logic [2:0]  MD_C0     = 3'h4;
    localparam logic [2:0]  MD_C1     = 3'h5;
    localparam logic [2:0]  MD_C2     = 3'h6;
    localparam logic [2:0]  MD_C3     = 3'h7;
    // Capture edges
    localparam logic [1:0]  EDGE_RISE = 2'h1;
    localparam logic [1:0]  EDGE_FALL = 2'h2;
    localparam logic [1:0]  EDGE_BOTH = 2'h3;
    // Time-base clock sources
    localparam logic [1:0]  SRC_PRESC = 2'h0;
    localparam logic [1:0]  SRC_NEIGH = 2'h1;
    localparam logic [1:0]  SRC_EXT   = 2'h2;
    // Staggered mode adds a divide by eight
    localparam logic [3:0]  STAG_SH   = 4'h3;
    localparam ccap_word_t  CNT_MAX   = 16'hFFFF;
    localparam ccap_word_t  VAL_RST   = 16'h0000;
endpackage

// [rtl/ccap_tbase.sv]
// Purpose: One reloadable 16-bit time base with selectable count source
// Assumes: Count source pulses are one cycle wide and already synchronous
// Notes:   upd and ovf are aligned with the new count value
`timescale 1ns/100ps
module ccap_tbase #(
    parameter bit EXT_OK = 1'b0
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               run,
    input  wire logic [1:0]         src,
    input  wire logic [2:0]         presc,
    input  wire logic               stagger,
    input  wire logic               neigh_pulse,
    input  wire logic               ext_pulse,
    input  wire ccap_pkg::ccap_word_t reload,
    output ccap_pkg::ccap_word_t    cnt,
    output logic                    upd,
    output logic                    ovf
);
    import ccap_pkg::*;

    logic [PDIV_W-1:0] pre_r;
    logic [PDIV_W-1:0] mask;
    logic [3:0]        shift;
    logic              tick;
    ccap_word_t        cnt_r;
    logic              upd_r;
    logic              ovf_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    always_comb begin
        shift = {1'b0, presc} + (stagger ? STAG_SH : 4'h0);
        mask  = PDIV_W'((1 << shift) - 1);
        case (src)
            SRC_PRESC: tick = (pre_r & mask) == '0;
            SRC_NEIGH: tick = neigh_pulse;
            SRC_EXT:   tick = EXT_OK && ext_pulse;
            default:   tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_r <= VAL_RST;
            upd_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            upd_r <= run && tick;
            ovf_r <= run && tick && cnt_r == CNT_MAX;
            if (run && tick) begin
                if (cnt_r == CNT_MAX) begin
                    cnt_r <= reload;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end

    assign cnt = cnt_r;
    assign upd = upd_r;
    assign ovf = ovf_r;
endmodule

// [rtl/ccap_array.sv]
// Purpose: Capture/compare array with two reloadable time bases
// Assumes: Pin inputs synchronous to CORE_CLK; config held stable
// Notes:   Channels 12..15 have no pin; pairs (k, k+8) share pin k
`timescale 1ns/100ps
// Functional notes
// - Sixteen channels, one-cycle or eight-cycle resolution
// - Two 16-bit time bases with reload
// - Time base clock from prescaler or neighbour
// - First time base also counts external input
// - Each register picks timer and capture/compare
// - Twelve registers own a capture/compare pin
// - Mode 0: interrupt on every match
// - Mode 1: pin toggles on every match
// - Mode 2: one interrupt per timer period
// - Mode 3: set on match, clear on overflow
// - Double mode: two registers toggle one pin
// - Single event option stops after one event
// - Capture latches timer and raises interrupt
// - Capture edge rising, falling or both
// - Compare registers checked against timer only in the cycle after it steps
module ccap_array (
    input  wire logic                         CORE_CLK,
    input  wire logic                         RST_B,
    input  wire logic                         STAGGER,
    input  wire logic                         T1_RUN,
    input  wire logic [1:0]                   T1_SRC,
    input  wire logic [2:0]                   T1_PRESC,
    input  wire ccap_pkg::ccap_word_t         T1_RELOAD,
    input  wire logic                         T2_RUN,
    input  wire logic [1:0]                   T2_SRC,
    input  wire logic [2:0]                   T2_PRESC,
    input  wire ccap_pkg::ccap_word_t         T2_RELOAD,
    input  wire logic                         NEIGH_OVF,
    input  wire logic                         EXT_COUNT,
    input  wire logic [3*ccap_pkg::NCH-1:0]   CH_MODE,
    input  wire logic [ccap_pkg::NCH-1:0]     CH_TSEL,
    input  wire logic [2*ccap_pkg::NCH-1:0]   CH_EDGE,
    input  wire logic [ccap_pkg::NCH-1:0]     CH_SINGLE,
    input  wire logic [ccap_pkg::NPAIR-1:0]   DBL_EN,
    input  wire logic [ccap_pkg::NCH-1:0]     CH_WR,
    input  wire ccap_pkg::ccap_word_t         CH_WDATA,
    input  wire logic [ccap_pkg::NPIN-1:0]    PIN_IN,
    output logic [ccap_pkg::NPIN-1:0]         PIN_OUT,
    output logic [ccap_pkg::NPIN-1:0]         PIN_OE,
    output logic [ccap_pkg::NCH*ccap_pkg::TW-1:0] CH_VALUE,
    output logic [ccap_pkg::NCH-1:0]          CH_IRQ,
    output ccap_pkg::ccap_word_t              T1_COUNT,
    output ccap_pkg::ccap_word_t              T2_COUNT
);
    import ccap_pkg::*;

    function automatic logic edge_hit(input logic cur, input logic prv,
                                      input logic [1:0] sel);
        edge_hit = (sel[0] && cur && !prv) || (sel[1] && !cur && prv);
    endfunction

    function automatic logic is_cmp(input logic [2:0] md);
        is_cmp = md[2];
    endfunction

    ccap_word_t        c1;
    ccap_word_t        c2;
    logic              u1;
    logic              u2;
    logic              o1;
    logic              o2;
    logic [NPIN-1:0]   s1_r;
    logic [NPIN-1:0]   s2_r;
    logic [NPIN-1:0]   s3_r;
    logic [2:0]        ext_r;
    logic              ext_pulse;
    ccap_word_t        val_r [NCH];
    logic [NCH-1:0]    once_r;
    logic              m2_seen_r;
    logic [NCH-1:0]    done_r;
    logic [NCH-1:0]    irq_r;
    logic [NCH-1:0]    match;
    logic [NCH-1:0]    capt;
    logic [NCH-1:0]    ch_ovf;
    logic [NPIN-1:0]   pin_r;
    logic [NPIN-1:0]   oe_r;
    logic [NPIN-1:0]   pin_nxt;
    logic [NPIN-1:0]   oe_nxt;

    // Input synchronisers; edges seen only between stages two and three
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            ext_r <= '0;
        end else begin
            s1_r  <= PIN_IN;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            ext_r <= {ext_r[1:0], EXT_COUNT};
        end
    end
    assign ext_pulse = ext_r[1] && !ext_r[2];

    ccap_tbase #(.EXT_OK(1'b1)) u_first_time_base (
        .clk         (CORE_CLK),
        .rst_b       (RST_B),
        .run         (T1_RUN),
        .src         (T1_SRC),
        .presc       (T1_PRESC),
        .stagger     (STAGGER),
        .neigh_pulse (NEIGH_OVF),
        .ext_pulse   (ext_pulse),
        .reload      (T1_RELOAD),
        .cnt         (c1),
        .upd         (u1),
        .ovf         (o1)
    );

    ccap_tbase #(.EXT_OK(1'b0)) u_second_time_base (
        .clk         (CORE_CLK),
        .rst_b       (RST_B),
        .run         (T2_RUN),
        .src         (T2_SRC),
        .presc       (T2_PRESC),
        .stagger     (STAGGER),
        .neigh_pulse (NEIGH_OVF),
        .ext_pulse   (1'b0),
        .reload      (T2_RELOAD),
        .cnt         (c2),
        .upd         (u2),
        .ovf         (o2)
    );

    // Match and capture detection per channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            logic [2:0] md;
            md        = CH_MODE[3*i +: 3];
            ch_ovf[i] = CH_TSEL[i] ? o2 : o1;
            match[i]  = is_cmp(md) && !done_r[i]
                        && (CH_TSEL[i] ? u2 : u1)
                        && (CH_TSEL[i] ? c2 : c1) == val_r[i]
                        && !((md == MD_C2 || md == MD_C3) && once_r[i]);
            capt[i]   = 1'b0;
            if (i < NPIN) begin
                capt[i] = md == MD_CAP && !done_r[i]
                          && edge_hit(s2_r[i % NPIN], s3_r[i % NPIN],
                                      CH_EDGE[2*i +: 2]);
            end
        end
    end

    // Channel registers; a software write wins over a capture
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            for (int i = 0; i < NCH; i++) begin
                val_r[i] <= VAL_RST;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (CH_WR[i]) begin
                    val_r[i] <= CH_WDATA;
                end else if (capt[i]) begin
                    val_r[i] <= CH_TSEL[i] ? c2 : c1;
                end
            end
        end
    end

    // Once per period: match sets, overflow clears, set wins
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            once_r <= '0;
        end else begin
            once_r <= (once_r & ~ch_ovf) | match;
        end
    end

    // Separate record of a channel 2 match, dropped on overflow
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            m2_seen_r <= 1'b0;
        end else if (match[2]) begin
            m2_seen_r <= 1'b1;
        end else if (ch_ovf[2]) begin
            m2_seen_r <= 1'b0;
        end
    end

    // Single event: disarm after one event until rewritten
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            done_r <= '0;
        end else begin
            done_r <= (done_r | ((match | capt) & CH_SINGLE)) & ~CH_WR;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            irq_r <= '0;
        end else begin
            irq_r <= match | capt;
        end
    end

    // Pin actions
    always_comb begin
        pin_nxt = pin_r;
        oe_nxt  = '0;
        for (int k = 0; k < NPIN; k++) begin
            logic [2:0] md;
            md = CH_MODE[3*k +: 3];
            if (md == MD_C1 || md == MD_C3) begin
                oe_nxt[k] = 1'b1;
            end
            if (md == MD_C3 && ch_ovf[k]) begin
                pin_nxt[k] = 1'b0;
            end
            if (match[k] && md == MD_C3) begin
                pin_nxt[k] = 1'b1;
            end
            if (match[k] && md == MD_C1) begin
                pin_nxt[k] = ~pin_r[k];
            end
        end
        for (int p = 0; p < NPAIR; p++) begin
            if (DBL_EN[p]) begin
                oe_nxt[p]  = 1'b1;
                pin_nxt[p] = pin_r[p] ^ match[p] ^ match[p + PAIR_OFS];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            pin_r <= '0;
            oe_r  <= '0;
        end else begin
            pin_r <= pin_nxt;
            oe_r  <= oe_nxt;
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            CH_VALUE[TW*i +: TW] = val_r[i];
        end
    end

    assign PIN_OUT  = pin_r;
    assign PIN_OE   = oe_r;
    assign CH_IRQ   = irq_r;
    assign T1_COUNT = c1;
    assign T2_COUNT = c2;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);

    a_mode0_irq: assert property (match[3] && CH_MODE[11:9] == MD_C0 |=> CH_IRQ[3])
        else $error("mode 0 match gave no interrupt");
    a_mode1_toggle: assert property (match[0] && CH_MODE[2:0] == MD_C1 && !DBL_EN[0]
        |=> PIN_OUT[0] != $past(PIN_OUT[0]))
        else $error("mode 1 pin did not toggle");
    a_mode2_once: assert property (CH_MODE[8:6] == MD_C2 && m2_seen_r && !ch_ovf[2]
        |-> !match[2])
        else $error("second mode 2 match in period");
    a_mode3_set: assert property (match[1] && CH_MODE[5:3] == MD_C3 && !DBL_EN[1]
        |=> PIN_OUT[1])
        else $error("mode 3 pin not set on match");
    a_mode3_clear: assert property (CH_MODE[5:3] == MD_C3 && ch_ovf[1] && !match[1]
        && !DBL_EN[1] |=> !PIN_OUT[1])
        else $error("mode 3 pin not cleared on overflow");
    a_single_stop: assert property (CH_SINGLE[8] && match[8] && !CH_WR[8]
        |=> !match[8] && !capt[8])
        else $error("single event channel fired again");
    a_capture_val: assert property (capt[5] && !CH_WR[5]
        |=> CH_VALUE[TW*5 +: TW] == $past(CH_TSEL[5] ? c2 : c1) && CH_IRQ[5])
        else $error("capture did not latch timer");
    a_rise_only: assert property (CH_MODE[17:15] == MD_CAP && CH_EDGE[11:10] == EDGE_RISE
        && !s2_r[5] && s3_r[5] |-> !capt[5])
        else $error("rising capture fired on falling edge");
    a_dbl_toggle: assert property (DBL_EN[7] && (match[7] ^ match[PAIR_OFS + 7])
        |=> PIN_OUT[7] != $past(PIN_OUT[7]))
        else $error("double mode pin did not toggle");
    a_pin_drive: assert property (CH_MODE[5:3] == MD_C3 |=> PIN_OE[1])
        else $error("mode 3 pin not driven");
    a_nopin_capt: assert property (CH_MODE[38:36] == MD_CAP |=> !CH_IRQ[12])
        else $error("pinless channel captured");
    a_pin_sync: assert property ($rose(PIN_IN[7]) ##1 PIN_IN[7] |-> ##1 s2_r[7])
        else $error("pin input not synchronised in two cycles");
    a_reload: assert property (o1 |-> c1 == $past(T1_RELOAD))
        else $error("timer did not reload on overflow");
    a_compare_eq: assert property (match[8] |-> (CH_TSEL[8] ? c2 : c1) == val_r[8])
        else $error("match without equality");

    c_capture: cover property (capt[4]);
    c_dbl_toggle: cover property (DBL_EN[7] && match[PAIR_OFS + 7]);
    c_mode3_cycle: cover property (CH_MODE[5:3] == MD_C3 && ch_ovf[1] ##1 !PIN_OUT[1]);
    c_overflow: cover property (o1);
    c_mode2_block: cover property (CH_MODE[8:6] == MD_C2 && m2_seen_r && u1 && c1 == val_r[2]);
endmodule

// [tb/ccap_far_model.sv]
// Purpose: Far side of the array: port pins and neighbour timer
// Assumes: Driven off the falling clock edge
// Notes:   Bench calls the tasks below
`timescale 1ns/100ps
module ccap_far_model (
    input  wire logic    clk,
    output logic [11:0]  pin_drv,
    output logic         neigh_ovf,
    output logic         ext_count
);
    initial begin
        pin_drv   = 12'h000;
        neigh_ovf = 1'b0;
        ext_count = 1'b0;
    end
    task automatic set_pins(input logic [11:0] v);
        @(negedge clk);
        pin_drv = v;
    endtask
    // One-cycle overflow pulse
    task automatic neigh_pulse();
        @(negedge clk);
        neigh_ovf = 1'b1;
        @(negedge clk);
        neigh_ovf = 1'b0;
    endtask
    // Level held long enough for the synchroniser
    task automatic ext_rise();
        @(negedge clk);
        ext_count = 1'b1;
        repeat (3) @(negedge clk);
        ext_count = 1'b0;
        repeat (3) @(negedge clk);
    endtask
endmodule

// [tb/tb_ccap_array.sv]
// Purpose: Self-checking bench for the capture/compare array
// Assumes: Inputs change on the falling edge
// Notes:   Interrupts are matched in order against a queue of notes
`timescale 1ns/100ps
module tb_ccap_array;
    import ccap_pkg::*;
    typedef struct packed {logic [3:0] ch; ccap_word_t val;} ccap_note_t;
    logic                clk;
    logic                rst_b;
    logic                stagger;
    logic                t1_run;
    logic                t2_run;
    logic [1:0]          t1_src;
    logic [1:0]          t2_src;
    logic [2:0]          t1_presc;
    logic [2:0]          t2_presc;
    ccap_word_t          t1_reload;
    ccap_word_t          t2_reload;
    ccap_word_t          ch_wdata;
    ccap_word_t          t1_count;
    ccap_word_t          t2_count;
    ccap_word_t          v0;
    ccap_word_t          a;
    logic [3*NCH-1:0]    ch_mode;
    logic [2*NCH-1:0]    ch_edge;
    logic [NCH-1:0]      ch_tsel;
    logic [NCH-1:0]      ch_single;
    logic [NCH-1:0]      ch_wr;
    logic [NCH-1:0]      ch_irq;
    logic [NPAIR-1:0]    dbl_en;
    logic [NPIN-1:0]     pin_in;
    logic [NPIN-1:0]     pin_out;
    logic [NPIN-1:0]     pin_oe;
    logic [NPIN-1:0]     pin_drv;
    logic                neigh_ovf;
    logic                ext_count;
    logic [NCH*TW-1:0]   ch_value;
    ccap_note_t          notes[$];
    int                  bad_count;
    int                  n_compared;
    int                  cycles;
    int                  seed;

    // Wire level: device wins where it drives
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drv);

    ccap_array i_dut (.CORE_CLK(clk), .RST_B(rst_b), .STAGGER(stagger), .T1_RUN(t1_run),
        .T1_SRC(t1_src), .T1_PRESC(t1_presc), .T1_RELOAD(t1_reload), .T2_RUN(t2_run),
        .T2_SRC(t2_src), .T2_PRESC(t2_presc), .T2_RELOAD(t2_reload), .NEIGH_OVF(neigh_ovf),
        .EXT_COUNT(ext_count), .CH_MODE(ch_mode), .CH_TSEL(ch_tsel), .CH_EDGE(ch_edge),
        .CH_SINGLE(ch_single), .DBL_EN(dbl_en), .CH_WR(ch_wr), .CH_WDATA(ch_wdata),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .CH_VALUE(ch_value),
        .CH_IRQ(ch_irq), .T1_COUNT(t1_count), .T2_COUNT(t2_count));

    ccap_far_model i_far (.clk(clk), .pin_drv(pin_drv), .neigh_ovf(neigh_ovf),
        .ext_count(ext_count));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic void exp_irq(input int ch, input ccap_word_t v);
        notes.push_back({4'(ch), v});
    endfunction

    task automatic set_ch(input int ch, input logic [2:0] md, input logic ts,
                          input logic [1:0] ed, input logic sg);
        ch_mode[3*ch+:3] = md;
        ch_tsel[ch] = ts;
        ch_edge[2*ch+:2] = ed;
        ch_single[ch] = sg;
    endtask

    task automatic wr(input int ch, input ccap_word_t v);
        @(negedge clk);
        ch_wr = NCH'(1) << ch;
        ch_wdata = v;
        @(negedge clk);
        ch_wr = '0;
        check(32'(ch_value[16*ch+:16]), 32'(v));
    endtask

    task automatic cfg(input int ch, input logic [2:0] md, input logic ts, input logic sg,
                       input ccap_word_t v);
        set_ch(ch, md, ts, 2'h0, sg);
        wr(ch, v);
    endtask

    // Timer 1 runs one step per cycle here
    task automatic wait_cnt(input ccap_word_t v);
        int n;
        n = 0;
        while (t1_count !== v && n < 70000) begin
            @(negedge clk);
            n++;
        end
        check(32'(t1_count), 32'(v));
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles > 80000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // Every interrupt consumes the oldest note
    always @(negedge clk) begin
        ccap_note_t nt;
        for (int i = 0; i < NCH; i++) begin
            if (ch_irq[i] === 1'b1) begin
                if (notes.size() == 0) begin
                    check(32'(i), 32'hFF);
                end else begin
                    nt = notes.pop_front();
                    check(32'(i), 32'(nt.ch));
                    check(32'(ch_value[16*i+:16]), 32'(nt.val));
                end
            end
        end
    end

    initial begin
        {rst_b, stagger, t1_run, t2_run, t1_src, t2_src, t1_presc, t2_presc} = '0;
        {t1_reload, t2_reload, ch_wdata, ch_mode, ch_edge, ch_tsel} = '0;
        {ch_single, ch_wr, dbl_en} = '0;
        bad_count = 0;
        n_compared = 0;
        cycles = 0;
        seed = $urandom(32'hACCB);
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        check({t1_count, t2_count}, 32'h0);
        check(32'({pin_oe, pin_out}), 32'h0);
        check(32'(ch_irq), 32'h0);
        // Prescaler divisions, last pass staggered
        t2_run = 1'b1;
        for (int p = 0; p < 5; p++) begin
            stagger = (p == 4);
            t2_presc = (p == 4) ? 3'h0 : 3'(p);
            repeat (8) @(negedge clk);
            a = t2_count;
            repeat (64) @(negedge clk);
            check(32'(16'(t2_count - a)), (p == 4) ? 32'd8 : 32'(64 >> p));
        end
        stagger = 1'b0;
        t2_src = SRC_NEIGH;
        rst_b = 1'b0;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        // Captures on timer 2, stepped by neighbour pulses
        set_ch(4, MD_CAP, 1'b1, EDGE_BOTH, 1'b0);
        set_ch(5, MD_CAP, 1'b1, EDGE_RISE, 1'b0);
        set_ch(6, MD_CAP, 1'b1, EDGE_FALL, 1'b0);
        set_ch(12, MD_CAP, 1'b1, EDGE_BOTH, 1'b0);
        for (int k = 1; k <= 4; k++) begin
            i_far.neigh_pulse();
            repeat (3) @(negedge clk);
            exp_irq(4, 16'(k));
            exp_irq((k % 2) ? 5 : 6, 16'(k));
            i_far.set_pins((k % 2) ? 12'h070 : 12'h000);
            repeat (6) @(negedge clk);
        end
        // Compare channels on both timers
        v0 = 16'h0040 + 16'($urandom_range(63));
        t1_reload = 16'hFFF0;
        dbl_en = 8'h80;
        cfg(0, MD_C1, 1'b0, 1'b0, v0);
        cfg(1, MD_C3, 1'b0, 1'b0, 16'h0080);
        cfg(2, MD_C2, 1'b0, 1'b0, 16'h0100);
        cfg(3, MD_C0, 1'b0, 1'b0, 16'h0100);
        cfg(7, MD_C0, 1'b0, 1'b0, 16'h0300);
        cfg(15, MD_C0, 1'b0, 1'b0, 16'h0310);
        cfg(8, MD_C0, 1'b0, 1'b1, 16'hFFF8);
        cfg(9, MD_C0, 1'b0, 1'b0, 16'hFFF8);
        cfg(10, MD_C0, 1'b1, 1'b0, 16'h0005);
        exp_irq(10, 16'h0005);
        i_far.neigh_pulse();
        exp_irq(0, v0);
        exp_irq(1, 16'h0080);
        exp_irq(2, 16'h0100);
        exp_irq(3, 16'h0100);
        exp_irq(3, 16'h0200);
        exp_irq(7, 16'h0300);
        exp_irq(15, 16'h0310);
        exp_irq(8, 16'hFFF8);
        exp_irq(9, 16'hFFF8);
        exp_irq(9, 16'hFFF8);
        t1_run = 1'b1;
        wait_cnt(16'h0110);
        check(32'({pin_oe[1:0], pin_out[1:0]}), 32'hF);
        wr(2, 16'h0200);
        wr(3, 16'h0200);
        wait_cnt(16'h0305);
        check(32'(pin_out[7]), 32'h1);
        wait_cnt(16'h0320);
        check(32'(pin_out[7]), 32'h0);
        wait_cnt(16'hFFFF);
        @(negedge clk);
        check(32'(t1_count), 32'hFFF0);
        t1_reload = 16'h0000;
        wait_cnt(16'hFFF2);
        check(32'(pin_out[1]), 32'h0);
        wait_cnt(16'h0002);
        // External count input on timer 1
        t1_src = SRC_EXT;
        repeat (4) @(negedge clk);
        a = t1_count;
        repeat (3) i_far.ext_rise();
        repeat (4) @(negedge clk);
        check(32'(16'(t1_count - a)), 32'd3);
        check(32'(notes.size()), 32'd0);
        report_and_stop();
    end
endmodule
